// [hdl/tlf_framer.sv]
// network-end framer: ternary block coding, scrambling, frame build and frame hunt
module tlf_framer
  import tlf_pkg::*;
#(
  parameter logic [21:0] FW_DOWN = TLF_FW_DOWN_DEF,
  parameter logic [21:0] FW_UP   = TLF_FW_UP_DEF
) (
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  input  wire logic [1:0] line_rx_sym,
  input  wire logic       line_rx_clk,
  output logic      [1:0] line_tx_sym,
  output logic            line_tx_stb,
  input  wire logic [3:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  output logic            tx_underrun,
  output logic      [3:0] rx_data,
  output logic            rx_valid,
  input  wire logic       rx_ready,
  output logic            rx_overrun,
  output logic            rx_code_err,
  input  wire logic [1:0] cl_tx_sym,
  output logic      [1:0] cl_rx_sym,
  input  wire logic [7:0] los_limit,
  output logic            frame_sync,
  output logic            sync_event
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_HUNT,
    ST_CONFIRM,
    ST_SYNC
  } tlf_rx_state_t;

  typedef struct packed {
    logic [2:0]              clk_sync;
    logic [2:0][1:0]         sym_sync;
    logic                    clk_lvl;
    logic [10:0]             acc;
    tlf_rx_state_t           st;
    logic [6:0]              rx_pos;
    logic [21:0]             win;
    logic [2:0]              hits;
    logic [7:0]              misses;
    logic [3:0]              rx_blk;
    logic [TLF_SCR_LEN-1:0]  rx_scr;
    logic [1:0]              cl_rx;
    logic [3:0]              rx_word;
    logic                    rx_push;
    logic                    code_err;
    logic [6:0]              tx_pos;
    tlf_alpha_t              tx_alpha;
    logic [3:0]              tx_blk;
    logic [TLF_SCR_LEN-1:0]  tx_scr;
    logic [1:0]              tx_sym;
    logic                    tx_stb;
    logic                    underrun;
    logic                    sync_evt;
  } tlf_state_t;

  tlf_state_t s_q;
  tlf_state_t s_d;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic is_payload(input logic [6:0] pos);
    is_payload = (pos >= TLF_POS_FIRST && pos <= TLF_PAY1_LAST) ||
                 (pos >= TLF_PAY2_FIRST && pos <= TLF_PAY2_LAST);
  endfunction

  // symbol index inside the current three-symbol block
  function automatic logic [1:0] blk_index(input logic [6:0] pos);
    logic [6:0] base;
    logic [6:0] rem;
    base      = (pos <= TLF_PAY1_LAST) ? TLF_POS_FIRST : TLF_PAY2_FIRST;
    rem       = (pos - base) % 7'h03;
    blk_index = rem[1:0];
  endfunction

  function automatic logic [6:0] pos_next(input logic [6:0] pos);
    pos_next = (pos == TLF_FRAME_LEN) ? TLF_POS_FIRST : pos + 7'h01;
  endfunction

  // self-synchronising scrambler, bit 3 first; descramble shifts in the line bit
  function automatic logic [TLF_SCR_LEN+3:0] scramble(
    input logic [3:0]             din,
    input logic [TLF_SCR_LEN-1:0] st,
    input int                     tap,
    input logic                   descr
  );
    logic [TLF_SCR_LEN-1:0] r;
    logic [3:0]             o;
    r = st;
    o = '0;
    for (int i = 3; i >= 0; i--) begin
      o[i] = din[i] ^ r[tap-1] ^ r[TLF_SCR_LEN-1];
      r    = {r[TLF_SCR_LEN-2:0], descr ? din[i] : o[i]};
    end
    scramble = {r, o};
  endfunction

  // decoding is alphabet-free: any table entry that matches names its nibble
  function automatic logic [4:0] decode(input logic [5:0] blk);
    logic [3:0] n;
    logic       hit;
    n   = 4'h0;
    hit = (blk == {SZ, SZ, SZ});
    for (int r = 0; r < 16; r++) begin
      for (int a = 0; a < 4; a++) begin
        if (TLF_ENC_TAB[r][a][7:2] == blk) begin
          n   = 4'(r);
          hit = 1'b1;
        end
      end
    end
    decode = {~hit, n};
  endfunction

  function automatic logic [7:0] clamp_limit(input logic [7:0] lim);
    if (lim < TLF_LOS_MIN) begin
      clamp_limit = TLF_LOS_MIN;
    end else if (lim > TLF_LOS_MAX) begin
      clamp_limit = TLF_LOS_MAX;
    end else begin
      clamp_limit = lim;
    end
  endfunction

  // ----------------------------------------------------------------
  // buffer toward the user
  // ----------------------------------------------------------------
  tlf_stream_if #(.W(4)) rx_in ();
  tlf_stream_if #(.W(4)) rx_out ();

  assign rx_in.data   = s_q.rx_word;
  assign rx_in.valid  = s_q.rx_push;
  assign rx_data      = rx_out.data;
  assign rx_valid     = rx_out.valid;
  assign rx_out.ready = rx_ready;
  // the line cannot be held off, so a full buffer can only be reported
  assign rx_overrun   = s_q.rx_push && !rx_in.ready;

  tlf_pair_buf #(.W(4)) u_buf (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .in_s     (rx_in.snk),
    .out_s    (rx_out.src)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic                   sym_evt;
  logic [1:0]             sym;
  logic [21:0]            win_n;
  logic                   match;
  logic [6:0]             rxp;
  logic [7:0]             limit;
  logic                   local_tick;
  logic                   tx_tick;
  logic [6:0]             txp;
  logic [4:0]             dec;
  logic [TLF_SCR_LEN+3:0] scr;
  logic [7:0]             enc;

  assign limit    = clamp_limit(los_limit);
  assign tx_ready = tx_tick && is_payload(txp) && (blk_index(txp) == 2'h0);

  always_comb begin
    s_d        = s_q;
    sym_evt    = 1'b0;
    sym        = s_q.sym_sync[2];
    win_n      = s_q.win;
    match      = 1'b0;
    rxp        = s_q.rx_pos;
    local_tick = 1'b0;
    tx_tick    = 1'b0;
    txp        = s_q.tx_pos;
    dec        = '0;
    scr        = '0;
    enc        = '0;

    s_d.clk_sync = {s_q.clk_sync[1:0], line_rx_clk};
    s_d.sym_sync = {s_q.sym_sync[1:0], line_rx_sym};
    s_d.rx_push  = 1'b0;
    s_d.tx_stb   = 1'b0;
    s_d.underrun = 1'b0;
    s_d.sync_evt = 1'b0;

    // recovered symbol clock; a rise counts once stages two and three agree
    if (s_q.clk_sync[2] == s_q.clk_sync[1] && s_q.clk_sync[2] != s_q.clk_lvl) begin
      s_d.clk_lvl = s_q.clk_sync[2];
      sym_evt     = s_q.clk_sync[2];
    end

    // local 120 kbaud rate for free running before sync
    if (32'(s_q.acc) + TLF_TICK_STEP >= TLF_TICK_MOD) begin
      s_d.acc    = 11'(32'(s_q.acc) + TLF_TICK_STEP - TLF_TICK_MOD);
      local_tick = 1'b1;
    end else begin
      s_d.acc = 11'(32'(s_q.acc) + TLF_TICK_STEP);
    end

    // ----------------------------------------------------------------
    // receive: frame hunt and payload
    // ----------------------------------------------------------------
    if (sym_evt) begin
      win_n     = {s_q.win[19:0], sym};
      s_d.win   = win_n;
      match     = (win_n == FW_DOWN);
      rxp       = pos_next(s_q.rx_pos);
      s_d.rx_pos = rxp;
      case (s_q.st)
        ST_HUNT: begin
          if (match) begin
            s_d.st     = ST_CONFIRM;
            s_d.rx_pos = TLF_FRAME_LEN;
            rxp        = TLF_FRAME_LEN;
            s_d.hits   = 3'h1;
          end
        end
        ST_CONFIRM: begin
          if (rxp == TLF_FRAME_LEN) begin
            if (!match) begin
              s_d.st = ST_HUNT;
            end else if (s_q.hits + 3'h1 == TLF_SYNC_HITS) begin
              s_d.st       = ST_SYNC;
              s_d.misses   = '0;
              s_d.rx_scr   = '0;
              s_d.code_err = 1'b0;
              s_d.sync_evt = 1'b1;
            end else begin
              s_d.hits = s_q.hits + 3'h1;
            end
          end
        end
        ST_SYNC: begin
          if (rxp == TLF_FRAME_LEN) begin
            if (match) begin
              s_d.misses = '0;
            end else if (s_q.misses + 8'h01 >= limit) begin
              s_d.st       = ST_HUNT;
              s_d.misses   = '0;
              s_d.sync_evt = 1'b1;
            end else begin
              s_d.misses = s_q.misses + 8'h01;
            end
          end
          if (is_payload(rxp)) begin
            case (blk_index(rxp))
              2'h0: s_d.rx_blk[3:2] = sym;
              2'h1: s_d.rx_blk[1:0] = sym;
              default: begin
                dec          = decode({s_q.rx_blk, sym});
                scr          = scramble(dec[3:0], s_q.rx_scr, TLF_TAP_DOWN, 1'b1);
                s_d.rx_scr   = scr[TLF_SCR_LEN+3:4];
                s_d.rx_word  = scr[3:0];
                s_d.rx_push  = 1'b1;
                s_d.code_err = dec[4];
              end
            endcase
          end else if (rxp == TLF_CL_POS) begin
            s_d.cl_rx = sym;
          end
        end
        default: s_d.st = ST_HUNT;
      endcase
    end

    // ----------------------------------------------------------------
    // transmit: slaved to receive timing once in sync
    // ----------------------------------------------------------------
    if (s_q.st == ST_SYNC) begin
      tx_tick = sym_evt;
      s_d.acc = '0;  // divider restarts, so no local tick crowds the last line tick at loss
      txp     = (rxp > TLF_FRAME_LEN - TLF_NT_OFFSET) ?
                rxp - (TLF_FRAME_LEN - TLF_NT_OFFSET) : rxp + TLF_NT_OFFSET;
    end else begin
      tx_tick = local_tick;
      txp     = pos_next(s_q.tx_pos);
    end

    if (tx_tick) begin
      s_d.tx_pos = txp;
      s_d.tx_stb = 1'b1;
      if (is_payload(txp)) begin
        case (blk_index(txp))
          2'h0: begin
            scr          = scramble(tx_valid ? tx_data : 4'h0, s_q.tx_scr,
                                    TLF_TAP_UP, 1'b0);
            s_d.tx_scr   = scr[TLF_SCR_LEN+3:4];
            enc          = TLF_ENC_TAB[scr[3:0]][s_q.tx_alpha];
            s_d.tx_alpha = tlf_alpha_t'(enc[1:0]);
            s_d.tx_sym   = enc[7:6];
            s_d.tx_blk   = enc[5:2];
            s_d.underrun = !tx_valid;
          end
          2'h1:    s_d.tx_sym = s_q.tx_blk[3:2];
          default: s_d.tx_sym = s_q.tx_blk[1:0];
        endcase
      end else if (txp == TLF_CL_POS) begin
        s_d.tx_sym = cl_tx_sym;
      end else begin
        s_d.tx_sym = FW_UP[2*(TLF_FRAME_LEN - txp) +: 2];
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q          <= '0;
      s_q.st       <= ST_HUNT;
      s_q.rx_pos   <= TLF_POS_FIRST;
      s_q.tx_pos   <= TLF_FRAME_LEN;
      s_q.tx_alpha <= ALPHABET_FIRST;
    end else begin
      s_q <= s_d;
    end
  end

  assign line_tx_sym = s_q.tx_sym;
  assign line_tx_stb = s_q.tx_stb;
  assign tx_underrun = s_q.underrun;
  assign rx_code_err = s_q.code_err;
  assign cl_rx_sym   = s_q.cl_rx;
  assign frame_sync  = (s_q.st == ST_SYNC);
  assign sync_event  = s_q.sync_evt;

endmodule

// [hdl/tlf_pair_buf.sv]
// two-entry buffer with valid and ready on both sides
module tlf_pair_buf
  import tlf_pkg::*;
#(
  parameter int W = 4
) (
  input  wire logic    core_clk,
  input  wire logic    arst_n,
  tlf_stream_if.snk    in_s,
  tlf_stream_if.src    out_s
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0][W-1:0] mem;
    logic              rd;
    logic              wr;
    logic [1:0]        cnt;
  } tlf_buf_state_t;

  tlf_buf_state_t s_q;
  tlf_buf_state_t s_d;
  logic           push;
  logic           pop;

  assign in_s.ready  = (s_q.cnt != 2'h2);
  assign out_s.valid = (s_q.cnt != 2'h0);
  assign out_s.data  = s_q.mem[s_q.rd];

  always_comb begin
    s_d  = s_q;
    push = in_s.valid && in_s.ready;
    pop  = out_s.valid && out_s.ready;
    if (push) begin
      s_d.mem[s_q.wr] = in_s.data;
      s_d.wr          = ~s_q.wr;
    end
    if (pop) begin
      s_d.rd = ~s_q.rd;
    end
    case ({push, pop})
      2'b10:   s_d.cnt = s_q.cnt + 2'h1;
      2'b01:   s_d.cnt = s_q.cnt - 2'h1;
      default: s_d.cnt = s_q.cnt;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

// [hdl/tlf_pkg.sv]
// constants, types and code table of the ternary line framer
package tlf_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int TLF_CLK_HZ    = 50_000_000;
  localparam int TLF_BAUD      = 120_000;
  localparam int TLF_RATE_GCD  = 40_000;
  localparam int TLF_TICK_STEP = TLF_BAUD / TLF_RATE_GCD;
  localparam int TLF_TICK_MOD  = TLF_CLK_HZ / TLF_RATE_GCD;

  // ----------------------------------------------------------------
  // frame layout, positions counted from 1
  // ----------------------------------------------------------------
  localparam logic [6:0] TLF_FRAME_LEN  = 7'h78;
  localparam logic [6:0] TLF_PAY1_LAST  = 7'h54;
  localparam logic [6:0] TLF_CL_POS     = 7'h55;
  localparam logic [6:0] TLF_PAY2_FIRST = 7'h56;
  localparam logic [6:0] TLF_PAY2_LAST  = 7'h6d;
  localparam logic [6:0] TLF_FW_FIRST   = 7'h6e;
  localparam logic [6:0] TLF_NT_OFFSET  = 7'h3c;
  localparam logic [6:0] TLF_POS_FIRST  = 7'h01;
  localparam int         TLF_FW_LEN     = 11;
  localparam logic [2:0] TLF_SYNC_HITS  = 3'h4;
  localparam logic [7:0] TLF_LOS_MIN    = 8'h3c;
  localparam logic [7:0] TLF_LOS_MAX    = 8'hc8;

  // ----------------------------------------------------------------
  // scrambler taps, in bit delays
  // ----------------------------------------------------------------
  localparam int TLF_SCR_LEN    = 23;
  localparam int TLF_TAP_DOWN   = 5;
  localparam int TLF_TAP_UP     = 18;

  // ----------------------------------------------------------------
  // symbols and alphabets
  // ----------------------------------------------------------------
  typedef logic [1:0] tlf_sym_t;
  localparam tlf_sym_t SZ = 2'h0;
  localparam tlf_sym_t SP = 2'h1;
  localparam tlf_sym_t SM = 2'h3;

  typedef enum logic [1:0] {
    ALPHABET_FIRST,
    ALPHABET_SECOND,
    ALPHABET_THIRD,
    ALPHABET_FOURTH
  } tlf_alpha_t;

  localparam logic [1:0] N1 = 2'h0;
  localparam logic [1:0] N2 = 2'h1;
  localparam logic [1:0] N3 = 2'h2;
  localparam logic [1:0] N4 = 2'h3;

  // default frame words: arbitrary 11-symbol patterns, first symbol at the top
  localparam logic [21:0] TLF_FW_DOWN_DEF = {SP, SP, SP, SM, SM, SP, SM, SZ, SP, SM, SM};
  localparam logic [21:0] TLF_FW_UP_DEF   = {SM, SP, SM, SM, SP, SM, SM, SM, SP, SP, SP};

  // ----------------------------------------------------------------
  // ternary block code: [nibble][alphabet] = {sym0, sym1, sym2, next}
  // ----------------------------------------------------------------
  localparam logic [7:0] TLF_ENC_TAB [0:15][0:3] = '{
    '{{SP,SZ,SP,N3}, {SZ,SM,SZ,N1}, {SZ,SM,SZ,N2}, {SZ,SM,SZ,N3}},
    '{{SZ,SM,SP,N1}, {SZ,SM,SP,N2}, {SZ,SM,SP,N3}, {SZ,SM,SP,N4}},
    '{{SP,SM,SZ,N1}, {SP,SM,SZ,N2}, {SP,SM,SZ,N3}, {SP,SM,SZ,N4}},
    '{{SZ,SZ,SP,N2}, {SZ,SZ,SP,N3}, {SZ,SZ,SP,N4}, {SM,SM,SZ,N2}},
    '{{SM,SP,SZ,N1}, {SM,SP,SZ,N2}, {SM,SP,SZ,N3}, {SM,SP,SZ,N4}},
    '{{SZ,SP,SP,N3}, {SM,SZ,SZ,N1}, {SM,SZ,SZ,N2}, {SM,SZ,SZ,N3}},
    '{{SM,SP,SP,N2}, {SM,SP,SP,N3}, {SM,SM,SP,N2}, {SM,SM,SP,N3}},
    '{{SM,SZ,SP,N1}, {SM,SZ,SP,N2}, {SM,SZ,SP,N3}, {SM,SZ,SP,N4}},
    '{{SP,SZ,SZ,N2}, {SP,SZ,SZ,N3}, {SP,SZ,SZ,N4}, {SZ,SM,SM,N2}},
    '{{SP,SM,SP,N2}, {SP,SM,SP,N3}, {SP,SM,SP,N4}, {SM,SM,SM,N1}},
    '{{SP,SP,SM,N2}, {SP,SP,SM,N3}, {SP,SM,SM,N2}, {SP,SM,SM,N3}},
    '{{SP,SZ,SM,N1}, {SP,SZ,SM,N2}, {SP,SZ,SM,N3}, {SP,SZ,SM,N4}},
    '{{SP,SP,SP,N4}, {SM,SP,SM,N1}, {SM,SP,SM,N2}, {SM,SP,SM,N3}},
    '{{SZ,SP,SZ,N2}, {SZ,SP,SZ,N3}, {SZ,SP,SZ,N4}, {SM,SZ,SM,N2}},
    '{{SZ,SP,SM,N1}, {SZ,SP,SM,N2}, {SZ,SP,SM,N3}, {SZ,SP,SM,N4}},
    '{{SP,SP,SZ,N3}, {SZ,SZ,SM,N1}, {SZ,SZ,SM,N2}, {SZ,SZ,SM,N3}}
  };

endpackage

// [hdl/tlf_stream_if.sv]
// valid/ready word stream between the framer and its buffer
interface tlf_stream_if #(
  parameter int W = 4
);
  logic [W-1:0] data;
  logic         valid;
  logic         ready;

  modport src (
    output data,
    output valid,
    input  ready
  );

  modport snk (
    input  data,
    input  valid,
    output ready
  );
endinterface

// [tb/tb.sv]
// self-checking bench of the ternary line framer
module tb
  import tlf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       core_clk = 1'b0;
  logic       arst_n   = 1'b0;
  logic       tx_valid = 1'b0;
  logic       rx_ready = 1'b0;
  logic       run      = 1'b0;
  logic       bad_word = 1'b1;
  logic [1:0] line_rx_sym, line_tx_sym, cl_rx_sym;
  logic       line_rx_clk, line_tx_stb, tx_ready, tx_underrun, rx_valid, rx_overrun;
  logic       rx_code_err, frame_sync, sync_event;
  logic [3:0] rx_data;
  logic [6:0] fe_pos;
  int         fe_frames;
  int         num_errors  = 0;
  int         comparisons = 0;
  int         cycles      = 0;

  always #10 core_clk = ~core_clk;

  tlf_framer i_tlf_framer (.core_clk(core_clk), .arst_n(arst_n), .line_rx_sym(line_rx_sym),
    .line_rx_clk(line_rx_clk), .line_tx_sym(line_tx_sym), .line_tx_stb(line_tx_stb),
    .tx_data(4'h5), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_underrun(tx_underrun),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_overrun(rx_overrun),
    .rx_code_err(rx_code_err), .cl_tx_sym(SP), .cl_rx_sym(cl_rx_sym), .los_limit(8'h05),
    .frame_sync(frame_sync), .sync_event(sync_event));
  tlf_far_end i_tlf_far_end (.core_clk(core_clk), .run(run), .bad_word(bad_word),
    .line_rx_sym(line_rx_sym), .line_rx_clk(line_rx_clk), .pos(fe_pos), .frames(fe_frames));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic step();
    @(posedge core_clk);
    #1;
  endtask
  task automatic chk(string what, int lo, int hi, logic [31:0] got);
    comparisons++;
    if ($isunknown(got) || got < lo || got > hi) begin
      num_errors++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask
  task automatic wait_pos1();
    int n;
    n = 0;
    while (fe_pos != TLF_POS_FIRST && n < 2000) begin step(); n++; end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk("frame_sync", 0, 0, frame_sync);
    chk("line_tx_stb", 0, 0, line_tx_stb);
    chk("tx_ready", 0, 0, tx_ready);
    $display("test reset done");
  endtask
  task automatic t_free_rate();
    int n, k;
    logic [7:0] sw;
    sw = '0;
    for (k = 0; k < 4; k++) begin
      n = 0;
      do begin step(); n++; end while (line_tx_stb !== 1'b1 && n < 2000);
      sw = {sw[5:0], line_tx_sym};
      if (k > 0) chk("free symbol spacing", 416, 417, n);
    end
    // zero nibbles from a cleared scrambler: + 0 + in the first alphabet, then 0 - 0 in the third
    chk("first tx symbols", {SP, SZ, SP, SZ}, {SP, SZ, SP, SZ}, sw);
    n = 0;
    while (tx_ready !== 1'b1 && n < 2000) begin step(); n++; end
    step();
    chk("tx_underrun", 1, 1, tx_underrun);
    $display("test free rate done");
  endtask
  task automatic t_bad_word();
    int seen;
    seen = 0;
    run = 1'b1;
    while (fe_frames < 6) begin step(); if (frame_sync === 1'b1) seen++; end
    chk("sync on foreign word", 0, 0, seen);
    $display("test foreign word done");
  endtask
  task automatic t_hunt();
    int f0, n;
    wait_pos1();
    bad_word = 1'b0;
    f0 = fe_frames;
    n = 0;
    while (frame_sync !== 1'b1 && n < 12000) begin step(); n++; end
    chk("frames to sync", 4, 4, fe_frames - f0);
    chk("sync_event at sync", 1, 1, sync_event);
    $display("test hunt done");
  endtask
  task automatic t_rx_payload();
    int f0, n, bad, k;
    rx_ready = 1'b1;
    f0 = fe_frames + 1;
    n = 0;
    bad = 0;
    k = 0;
    while (fe_frames != f0 + 1 && k < 3000) begin
      step();
      k++;
      if (fe_frames == f0 && rx_valid === 1'b1) begin n++; bad += (rx_data !== 4'h0); end
    end
    chk("nibbles per frame", 36, 36, n);
    chk("nonzero nibbles", 0, 0, bad);
    chk("cl_rx_sym", SM, SM, cl_rx_sym);
    chk("rx_code_err", 0, 0, rx_code_err);
    $display("test rx payload done");
  endtask
  task automatic t_rx_stall();
    int n, seen;
    rx_ready = 1'b0;
    seen = 0;
    for (n = 0; n < 200; n++) begin step(); seen += (rx_overrun === 1'b1); end
    chk("rx_overrun count", 1, 200, seen);
    chk("rx_valid held", 1, 1, rx_valid);
    rx_ready = 1'b1;
    n = 0;
    while (rx_valid === 1'b1 && n < 8) begin step(); n++; end
    chk("drain cycles", 2, 3, n);
    $display("test rx stall done");
  endtask
  task automatic t_tx_frame();
    logic [21:0] h;
    logic [1:0]  s85;
    int          n, rdy, k;
    h = '0;
    s85 = 2'h2;
    n = 0;
    rdy = 0;
    k = 0;
    tx_valid = 1'b1;
    while (h !== TLF_FW_UP_DEF && k < 3000) begin
      step();
      k++;
      if (line_tx_stb === 1'b1) h = {h[19:0], line_tx_sym};
    end
    chk("rx position at tx word end", 59, 61, fe_pos);
    while (n < 120 && k < 6000) begin
      step();
      k++;
      rdy += (tx_ready === 1'b1);
      if (line_tx_stb === 1'b1) begin
        n++;
        h = {h[19:0], line_tx_sym};
        if (n == 85) s85 = line_tx_sym;
      end
    end
    chk("tx frame word", TLF_FW_UP_DEF, TLF_FW_UP_DEF, h);
    chk("tx blocks per frame", 36, 36, rdy);
    chk("tx maintenance symbol", SP, SP, s85);
    $display("test tx frame done");
  endtask
  task automatic t_los();
    int f0, n;
    wait_pos1();
    bad_word = 1'b1;
    f0 = fe_frames;
    n = 0;
    while (frame_sync === 1'b1 && n < 70000) begin step(); n++; end
    chk("frames to loss", 60, 61, fe_frames - f0);
    chk("sync_event at loss", 1, 1, sync_event);
    $display("test loss done");
  endtask

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 100000) begin
      num_errors++;
      $display("timeout after %0d cycles", cycles);
      end_of_test();
    end
  end
  initial begin
    repeat (2) @(posedge core_clk);
    #1;
    t_reset();
    arst_n = 1'b1;
    t_free_rate();
    t_bad_word();
    t_hunt();
    t_rx_payload();
    t_rx_stall();
    t_tx_frame();
    t_los();
    t_hunt();
    end_of_test();
  end
endmodule

// [tb/tlf_far_end.sv]
// far loop end model: sends frames of all-zero payload toward the framer
module tlf_far_end
  import tlf_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       run,
  input  wire logic       bad_word,
  output logic      [1:0] line_rx_sym,
  output logic            line_rx_clk,
  output logic      [6:0] pos,
  output int              frames
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0]  ph;
  logic [6:0]  pn;
  logic [21:0] fw;
  // bad_word sends the other direction's word
  assign fw = bad_word ? TLF_FW_UP_DEF : TLF_FW_DOWN_DEF;
  assign pn = (pos == TLF_FRAME_LEN) ? TLF_POS_FIRST : pos + 7'h01;
  initial begin
    ph = 3'h0;
    pos = TLF_FRAME_LEN;
    frames = 0;
    line_rx_clk = 1'b0;
    line_rx_sym = 2'h0;
  end
  function automatic logic [1:0] sym_at(logic [6:0] p);
    if (p >= TLF_FW_FIRST) return fw[21 - 2 * int'(p - TLF_FW_FIRST) -: 2];
    if (p == TLF_CL_POS) return SM;
    return SZ;
  endfunction
  // symbol changes at the falling clock, four core cycles from each rising edge
  always @(posedge core_clk) begin
    if (!run) begin
      line_rx_clk <= 1'b0;
      line_rx_sym <= ~line_rx_sym;
      ph <= 3'h0;
    end else begin
      ph <= ph + 3'h1;
      if (ph == 3'h0) begin
        line_rx_clk <= 1'b0;
        line_rx_sym <= sym_at(pn);
        pos <= pn;
        if (pn == TLF_FRAME_LEN) frames <= frames + 1;
      end
      if (ph == 3'h4) line_rx_clk <= 1'b1;
    end
  end
endmodule

// [tb/tlf_framer_assertions.sv]
// port-level checks of the ternary line framer
module tlf_framer_chk (
  input wire logic       core_clk,
  input wire logic       arst_n,
  input wire logic       tx_valid,
  input wire logic       tx_ready,
  input wire logic       tx_underrun,
  input wire logic [1:0] line_tx_sym,
  input wire logic       line_tx_stb,
  input wire logic [3:0] rx_data,
  input wire logic       rx_valid,
  input wire logic       rx_ready,
  input wire logic       frame_sync,
  input wire logic       sync_event
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // ----------------------------------------------------------------
  // block start steps, symbol strobes, sync events, rx hold
  // ----------------------------------------------------------------
  sequence take_s; tx_ready && tx_valid; endsequence
  sequence miss_s; tx_ready && !tx_valid; endsequence
  sequence sym_s; line_tx_stb && line_tx_sym != 2'h2; endsequence
  take_sends_a: assert property (take_s |=> sym_s ##0 !tx_underrun)
    else $error("taken nibble not sent cleanly");
  miss_fills_a: assert property (miss_s |=> sym_s ##0 tx_underrun)
    else $error("missing nibble not flagged");
  underrun_cause_a: assert property (tx_underrun |-> $past(tx_ready) && !$past(tx_valid))
    else $error("underrun without a missed block start");
  stb_gap_a: assert property (line_tx_stb |=> !line_tx_stb [*2])
    else $error("symbol strobes too close");
  sym_hold_a: assert property (!line_tx_stb |-> $stable(line_tx_sym))
    else $error("tx symbol changed without strobe");
  block_gap_a: assert property (tx_ready |=> !tx_ready [*3])
    else $error("block starts too close");
  event_cause_a: assert property (sync_event |-> frame_sync != $past(frame_sync))
    else $error("sync event without state change");
  sync_evented_a: assert property (frame_sync != $past(frame_sync) |-> sync_event)
    else $error("sync change without event");
  event_pulse_a: assert property (sync_event |=> !sync_event)
    else $error("sync event longer than one cycle");
  rx_hold_a: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
    else $error("stalled rx word lost or changed");
endmodule

bind tlf_framer tlf_framer_chk i_tlf_framer_chk (.core_clk(core_clk), .arst_n(arst_n),
  .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_underrun(tx_underrun),
  .line_tx_sym(line_tx_sym), .line_tx_stb(line_tx_stb), .rx_data(rx_data),
  .rx_valid(rx_valid), .rx_ready(rx_ready), .frame_sync(frame_sync), .sync_event(sync_event));
